// ### hdl/aux_seq_defines.svh
// register offsets, field positions, reset values and timing counts of the auxiliary sequencer
`ifndef AUX_SEQ_DEFINES_SVH
`define AUX_SEQ_DEFINES_SVH

`define AUX_TIMING_OFFSET 8'h8c
`define AUX_SPARE_OFFSET 8'h8d
`define AUX_OFFSET_OFFSET 8'h8e

`define AUX_MODE_MSB 15
`define AUX_MODE_LSB 14
`define AUX_DELAY_MSB 10
`define AUX_DELAY_LSB 8
`define AUX_RATIO_MSB 1
`define AUX_RATIO_LSB 0
`define AUX_SPARE_MSB 7
`define AUX_SPARE_LSB 0

`define AUX_TIMING_RESET 16'h0000
`define AUX_SPARE_RESET 16'h0000
`define AUX_OFFSET_RESET 16'h0000

// settling delays, in master-clock periods
`define AUX_DELAY_0 13'h0010
`define AUX_DELAY_1 13'h0040
`define AUX_DELAY_2 13'h0080
`define AUX_DELAY_3 13'h0100
`define AUX_DELAY_4 13'h0200
`define AUX_DELAY_5 13'h0400
`define AUX_DELAY_6 13'h0800
`define AUX_DELAY_7 13'h1000

// conversion times per ratio, in master-clock periods
`define AUX_CONV_0 13'h0180
`define AUX_CONV_1 13'h0200
`define AUX_CONV_2 13'h0300
`define AUX_CONV_3 13'h0500

`endif

// ### hdl/aux_seq_pkg.sv
// types shared by the auxiliary sequencer configuration block
package aux_seq_pkg;

  typedef enum logic [1:0] {
    MODE_SW_ONCE = 2'h0,
    MODE_TRIG_ONCE = 2'h1,
    MODE_CONT_A = 2'h2,
    MODE_CONT_B = 2'h3
  } seq_mode_e;

  // gray order along idle -> settle -> convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SETTLE = 2'h1,
    ST_CONVERT = 2'h3
  } seq_state_e;

  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [15:0] data;
  } reg_req_s;

endpackage : aux_seq_pkg

// ### hdl/offset_subtract.sv
// offset removal with saturation for raw auxiliary results
`timescale 1ns/1ps
`include "aux_seq_defines.svh"

module offset_subtract #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // master clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic inValid, // raw result strobe
  input wire logic [WIDTH-1:0] inData, // raw result, two's complement
  input wire logic [WIDTH-1:0] offsetWord, // aux_offset_word
  output logic outValid, // corrected result strobe
  output logic [WIDTH-1:0] outData // corrected result
);

  logic [WIDTH:0] diff;
  logic next_outValid;
  logic [WIDTH-1:0] next_outData;

  // one extra bit catches overflow; clip rather than wrap so a sign flip never appears
  always_comb begin
    diff = {inData[WIDTH-1], inData} - {offsetWord[WIDTH-1], offsetWord};
    next_outValid = inValid;
    next_outData = outData;
    if (inValid) begin
      if (diff[WIDTH] != diff[WIDTH-1]) begin
        next_outData = diff[WIDTH] ? {1'b1, {(WIDTH-1){1'b0}}} : {1'b0, {(WIDTH-1){1'b1}}};
      end else begin
        next_outData = diff[WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      outValid <= next_outValid;
      outData <= next_outData;
    end
  end

  low_clip_a: assert property (@(posedge clk) disable iff (sys_rst)
    inValid && inData[WIDTH-1] && !offsetWord[WIDTH-1] && diff[WIDTH] != diff[WIDTH-1]
    |=> outValid && outData == {1'b1, {(WIDTH-1){1'b0}}})
    else $error("negative overflow not clipped to minus full scale");

endmodule : offset_subtract

// ### hdl/aux_seq_config.sv
// sequencer start, settling delay, ratio and offset configuration of the auxiliary converter
// Behaviour
// - a two-bit mode field picks how sequences start, and the start bit aborts and restarts any sequence in all modes.
// - in mode 00b each start bit runs the configured sequence once and then stops.
// - in mode 01b a single sequence starts on a falling data-ready edge of the primary converter or on the start bit.
// - in mode 01b data-ready edges seen while a sequence runs are ignored and neither abort nor restart it.
// - modes 10b and 11b both run continuously once started by the start bit, repeating with no further trigger.
// - before each step a settling delay of 16, 64, 128, 256, 512, 1024, 2048 or 4096 clocks is waited, per a 3-bit code.
// - a two-bit ratio code picks 64, 128, 256 or 512 with conversion times of 384, 512, 768 or 1280 clocks.
// - the spare register holds eight writable bits with no effect and its upper eight bits read zero.
// - the offset word is a 16-bit two's complement value whose step size halves at gains 2 and 4.
`timescale 1ns/1ps
`include "aux_seq_defines.svh"

module aux_seq_config #(
  parameter int CW = 13, // width of the timing counter
  parameter int DW = 16 // result and register width
) (
  input wire logic clk, // master clock, 20 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire aux_seq_pkg::reg_req_s regReq, // register write from the serial front end
  input wire logic [7:0] regRdAddr, // register read address
  output logic [DW-1:0] regRdData, // read data, one cycle after address
  input wire logic sequenceStartBit, // one-cycle pulse when the start bit is written
  input wire logic auxConverterEnable, // converter enable level
  input wire logic [1:0] lastStep, // index of the final enabled step
  input wire logic primaryDataReadyN, // data-ready pin of the primary converter, low active
  input wire logic rawValid, // raw result strobe from the modulator filter
  input wire logic [DW-1:0] rawData, // raw result, two's complement
  output logic seqBusy, // a sequence is running
  output logic convStart, // pulse: conversion of a step begins
  output logic [1:0] sequenceCounter, // current step index
  output logic [1:0] auxRatioSelect, // ratio code for the filter
  output logic corrValid, // corrected result strobe
  output logic [DW-1:0] corrData // offset-corrected result
);

  logic [DW-1:0] timingReg, spareReg, offsetReg;
  logic [DW-1:0] next_timingReg, next_spareReg, next_offsetReg, next_regRdData;
  aux_seq_pkg::seq_state_e state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [1:0] next_sequenceCounter;
  logic next_convStart, next_seqBusy;
  logic drdySync1, drdySync2, drdyPrev;
  logic drdyFall, restart, stepDone;
  logic [1:0] mode;
  logic [CW-1:0] delayCycles, convCycles;

  assign mode = timingReg[`AUX_MODE_MSB:`AUX_MODE_LSB];

  // settling delay lookup
  function automatic logic [CW-1:0] delay_of(input logic [2:0] sel);
    case (sel)
      3'h0: delay_of = `AUX_DELAY_0;
      3'h1: delay_of = `AUX_DELAY_1;
      3'h2: delay_of = `AUX_DELAY_2;
      3'h3: delay_of = `AUX_DELAY_3;
      3'h4: delay_of = `AUX_DELAY_4;
      3'h5: delay_of = `AUX_DELAY_5;
      3'h6: delay_of = `AUX_DELAY_6;
      default: delay_of = `AUX_DELAY_7;
    endcase
  endfunction : delay_of

  // conversion time lookup per ratio
  function automatic logic [CW-1:0] conv_of(input logic [1:0] sel);
    case (sel)
      2'h0: conv_of = `AUX_CONV_0;
      2'h1: conv_of = `AUX_CONV_1;
      2'h2: conv_of = `AUX_CONV_2;
      default: conv_of = `AUX_CONV_3;
    endcase
  endfunction : conv_of

  assign delayCycles = delay_of(timingReg[`AUX_DELAY_MSB:`AUX_DELAY_LSB]);
  assign convCycles = conv_of(timingReg[`AUX_RATIO_MSB:`AUX_RATIO_LSB]);

  // data-ready pin crosses in by two flops; edge detect only looks at the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drdySync1 <= 1'b1;
      drdySync2 <= 1'b1;
      drdyPrev <= 1'b1;
    end else begin
      drdySync1 <= primaryDataReadyN;
      drdySync2 <= drdySync1;
      drdyPrev <= drdySync2;
    end
  end

  assign drdyFall = drdyPrev && !drdySync2;

  // register writes and readback; reserved bits are never stored so they read zero
  always_comb begin
    next_timingReg = timingReg;
    next_spareReg = spareReg;
    next_offsetReg = offsetReg;
    if (regReq.wrEn) begin
      case (regReq.addr)
        `AUX_TIMING_OFFSET: begin
          next_timingReg = '0;
          next_timingReg[`AUX_MODE_MSB:`AUX_MODE_LSB] = regReq.data[`AUX_MODE_MSB:`AUX_MODE_LSB];
          next_timingReg[`AUX_DELAY_MSB:`AUX_DELAY_LSB] = regReq.data[`AUX_DELAY_MSB:`AUX_DELAY_LSB];
          next_timingReg[`AUX_RATIO_MSB:`AUX_RATIO_LSB] = regReq.data[`AUX_RATIO_MSB:`AUX_RATIO_LSB];
        end
        `AUX_SPARE_OFFSET: begin
          next_spareReg = '0;
          next_spareReg[`AUX_SPARE_MSB:`AUX_SPARE_LSB] = regReq.data[`AUX_SPARE_MSB:`AUX_SPARE_LSB];
        end
        `AUX_OFFSET_OFFSET: next_offsetReg = regReq.data;
        default: next_offsetReg = offsetReg;
      endcase
    end
    case (regRdAddr)
      `AUX_TIMING_OFFSET: next_regRdData = timingReg;
      `AUX_SPARE_OFFSET: next_regRdData = spareReg;
      `AUX_OFFSET_OFFSET: next_regRdData = offsetReg;
      default: next_regRdData = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timingReg <= `AUX_TIMING_RESET;
      spareReg <= `AUX_SPARE_RESET;
      offsetReg <= `AUX_OFFSET_RESET;
      regRdData <= '0;
    end else begin
      timingReg <= next_timingReg;
      spareReg <= next_spareReg;
      offsetReg <= next_offsetReg;
      regRdData <= next_regRdData;
    end
  end

  // start bit restarts in every mode; a data-ready edge only counts while idle in mode 01b
  assign restart = sequenceStartBit ||
    (mode == aux_seq_pkg::MODE_TRIG_ONCE && drdyFall && state == aux_seq_pkg::ST_IDLE);
  assign stepDone = state == aux_seq_pkg::ST_CONVERT && cnt == '0;

  // sequencer: settle for the delay, convert for the ratio's time, then next step
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sequenceCounter = sequenceCounter;
    next_convStart = 1'b0;
    if (!auxConverterEnable) begin
      next_state = aux_seq_pkg::ST_IDLE; // disabling clears the step counter
      next_cnt = '0;
      next_sequenceCounter = 2'h0;
    end else if (restart) begin
      next_state = aux_seq_pkg::ST_SETTLE;
      next_cnt = delayCycles - 1'b1;
      next_sequenceCounter = 2'h0;
    end else begin
      case (state)
        aux_seq_pkg::ST_IDLE: next_cnt = '0;
        aux_seq_pkg::ST_SETTLE: begin
          if (cnt == '0) begin
            next_state = aux_seq_pkg::ST_CONVERT;
            next_cnt = convCycles - 1'b1;
            next_convStart = 1'b1;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
        aux_seq_pkg::ST_CONVERT: begin
          if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
          end else if (sequenceCounter != lastStep) begin
            next_state = aux_seq_pkg::ST_SETTLE;
            next_cnt = delayCycles - 1'b1;
            next_sequenceCounter = sequenceCounter + 2'h1;
          end else if (mode[1]) begin
            next_state = aux_seq_pkg::ST_SETTLE;
            next_cnt = delayCycles - 1'b1;
            next_sequenceCounter = 2'h0;
          end else begin
            next_state = aux_seq_pkg::ST_IDLE;
          end
        end
        default: next_state = aux_seq_pkg::ST_IDLE;
      endcase
    end
    next_seqBusy = next_state != aux_seq_pkg::ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= aux_seq_pkg::ST_IDLE;
      cnt <= '0;
      sequenceCounter <= 2'h0;
      convStart <= 1'b0;
      seqBusy <= 1'b0;
      auxRatioSelect <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sequenceCounter <= next_sequenceCounter;
      convStart <= next_convStart;
      seqBusy <= next_seqBusy;
      auxRatioSelect <= timingReg[`AUX_RATIO_MSB:`AUX_RATIO_LSB];
    end
  end

  // corrected result goes to gain correction downstream
  offset_subtract #(.WIDTH(DW)) offsetStage (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(rawValid),
    .inData(rawData),
    .offsetWord(offsetReg),
    .outValid(corrValid),
    .outData(corrData)
  );

  // helper counters of time spent in each phase, read only by checks
  logic [CW-1:0] settleRun, convRun;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settleRun <= '0;
      convRun <= '0;
    end else begin
      settleRun <= (state == aux_seq_pkg::ST_SETTLE && !(restart && auxConverterEnable)) ? settleRun + 1'b1 : '0;
      convRun <= (state == aux_seq_pkg::ST_CONVERT && next_state == aux_seq_pkg::ST_CONVERT) ? convRun + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  start_restart_a: assert property (
    sequenceStartBit && auxConverterEnable |=> state == aux_seq_pkg::ST_SETTLE && sequenceCounter == 2'h0
      && cnt == $past(delayCycles) - 1'b1)
    else $error("start bit did not restart the sequence");

  single_shot_a: assert property (
    stepDone && !mode[1] && sequenceCounter == lastStep && !restart && auxConverterEnable
    |=> state == aux_seq_pkg::ST_IDLE && !seqBusy)
    else $error("single-shot sequence did not stop");

  drdy_trigger_a: assert property (
    mode == aux_seq_pkg::MODE_TRIG_ONCE && state == aux_seq_pkg::ST_IDLE && auxConverterEnable
      && drdyPrev && !drdySync2 |=> state == aux_seq_pkg::ST_SETTLE ##0 seqBusy)
    else $error("data-ready edge did not start a sequence");

  drdy_ignore_a: assert property (
    state == aux_seq_pkg::ST_SETTLE && cnt != '0 && drdyFall && !sequenceStartBit && auxConverterEnable
    |=> cnt == $past(cnt) - 1'b1 && sequenceCounter == $past(sequenceCounter))
    else $error("data-ready edge disturbed a running sequence");

  continuous_a: assert property (
    stepDone && mode[1] && sequenceCounter == lastStep && !restart && auxConverterEnable
    |=> state == aux_seq_pkg::ST_SETTLE && sequenceCounter == 2'h0)
    else $error("continuous sequence did not repeat");

  settle_time_a: assert property (
    convStart |-> settleRun == delayCycles)
    else $error("settling delay length wrong");

  conv_time_a: assert property (
    stepDone && auxConverterEnable && !restart |-> convRun == convCycles - 1'b1)
    else $error("conversion time wrong");

  spare_upper_a: assert property (
    regRdAddr == `AUX_SPARE_OFFSET |=> regRdData[15:8] == 8'h00 && regRdData[7:0] == $past(spareReg[7:0]))
    else $error("spare register readback wrong");

endmodule : aux_seq_config

// ### bench/aux_seq_config_test.sv
// self-checking bench for the auxiliary sequencer configuration block
`timescale 1ns/1ps
`include "aux_seq_defines.svh"

module aux_seq_config_test;
  logic clk, sysRst, startBit, enable, dataReadyN, rawValid, seqBusy, convStart, corrValid;
  aux_seq_pkg::reg_req_s regReq;
  logic [7:0] rdAddr;
  logic [15:0] rdData, rawData, corrData;
  logic [1:0] lastStep, stepCount, ratioSel;
  int failures, cmpCount, cycles, n;
  int dly[8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
  int cnv[4] = '{384, 512, 768, 1280};

  aux_seq_config u_aux_seq_config (.clk(clk), .sys_rst(sysRst), .regReq(regReq), .regRdAddr(rdAddr),
    .regRdData(rdData), .sequenceStartBit(startBit), .auxConverterEnable(enable), .lastStep(lastStep),
    .primaryDataReadyN(dataReadyN), .rawValid(rawValid), .rawData(rawData), .seqBusy(seqBusy),
    .convStart(convStart), .sequenceCounter(stepCount), .auxRatioSelect(ratioSel),
    .corrValid(corrValid), .corrData(corrData));

  // 50 ns master clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, sized well above the longest delay and ratio sweep
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      $display("CHECK FAILED at %0t: timeout", $time);
      complete_run();
    end
  end

  task complete_run();
    $display("checks %0d, mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) #1 regReq = '{wrEn: 1'b1, addr: a, data: d};
    @(posedge clk) #1 regReq.wrEn = 1'b0;
  endtask : wr

  // readback is registered, so the word shows one edge after the address
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) #1 rdAddr = a;
    @(posedge clk) #1 chk(rdData, exp, "readback");
  endtask : rd

  task pulse_start();
    @(posedge clk) #1 startBit = 1'b1;
    @(posedge clk) #1 startBit = 1'b0;
  endtask : pulse_start

  // a bounded wait; n is the cycles spent, 9999 when it never came
  task wait_for(input int which, input int limit);
    n = 0;
    do begin
      @(posedge clk) #1 n++;
    end while (!((which == 0 && seqBusy === 1'b1) || (which == 1 && convStart === 1'b1) ||
                 (which == 2 && seqBusy === 1'b0)) && n < limit);
    if (n >= limit) n = 9999;
  endtask : wait_for

  // settings are only changed with the converter disabled
  task config_timing(input logic [1:0] mode, input logic [2:0] dcode, input logic [1:0] rcode);
    @(posedge clk) #1 enable = 1'b0;
    wr(`AUX_TIMING_OFFSET, {mode, 3'h0, dcode, 6'h00, rcode});
    @(posedge clk) #1 enable = 1'b1;
  endtask : config_timing

  task offs(input logic [15:0] o, input logic [15:0] r, input logic [15:0] exp);
    wr(`AUX_OFFSET_OFFSET, o);
    @(posedge clk) #1 rawValid = 1'b1;
    rawData = r;
    @(posedge clk) #1 rawValid = 1'b0;
    chk({15'h0000, corrValid}, 16'h0001, "corrected strobe");
    chk(corrData, exp, "corrected value");
  endtask : offs

  initial begin
    sysRst = 1'b1;
    startBit = 1'b0;
    enable = 1'b0;
    dataReadyN = 1'b1;
    rawValid = 1'b0;
    rawData = 16'h0000;
    lastStep = 2'h0;
    rdAddr = 8'h00;
    regReq = '{wrEn: 1'b0, addr: 8'h00, data: 16'h0000};
    failures = 0;
    cmpCount = 0;
    repeat (12) @(posedge clk);
    #1 sysRst = 1'b0;
    // reset values, field masks, unmapped place
    rd(`AUX_TIMING_OFFSET, 16'h0000);
    rd(`AUX_SPARE_OFFSET, 16'h0000);
    rd(`AUX_OFFSET_OFFSET, 16'h0000);
    wr(`AUX_TIMING_OFFSET, 16'hffff);
    rd(`AUX_TIMING_OFFSET, 16'hc703);
    chk({14'h0000, ratioSel}, 16'h0003, "ratio copy");
    wr(`AUX_SPARE_OFFSET, 16'habcd);
    rd(`AUX_SPARE_OFFSET, 16'h00cd);
    wr(8'h8f, 16'h1234);
    rd(8'h8f, 16'h0000);
    wr(`AUX_OFFSET_OFFSET, 16'h8001);
    rd(`AUX_OFFSET_OFFSET, 16'h8001);
    // offset removal, both saturation limits
    offs(16'h0001, 16'h8000, 16'h8000);
    offs(16'hffff, 16'h7fff, 16'h7fff);
    offs(16'h0002, 16'h0005, 16'h0003);
    offs(16'hfffe, 16'hfff0, 16'hfff2);
    // every delay code, ratio codes cycling, single shot by start bit
    for (int i = 0; i < 8; i++) begin
      config_timing(2'h0, i[2:0], i[1:0]);
      pulse_start();
      wait_for(0, 4);
      chk(n[15:0], 16'h0001, "busy after start");
      wait_for(1, 5000);
      // the busy wait already spent the first settle cycle
      chk(n[15:0] + 16'h0001, dly[i][15:0], "settling delay");
      chk({14'h0000, ratioSel}, {14'h0000, i[1:0]}, "ratio select");
      wait_for(2, 2000);
      chk(n[15:0], cnv[i % 4][15:0], "conversion time");
      repeat (20) @(posedge clk);
      #1 chk({15'h0000, seqBusy}, 16'h0000, "stays stopped");
    end
    // mode 00 ignores the data-ready pin
    @(posedge clk) #1 dataReadyN = 1'b0;
    repeat (10) @(posedge clk);
    #1 chk({15'h0000, seqBusy}, 16'h0000, "pin ignored in mode 00");
    // abort and restart mid conversion
    config_timing(2'h0, 3'h0, 2'h0);
    pulse_start();
    repeat (100) @(posedge clk);
    pulse_start();
    wait_for(1, 5000);
    chk(n[15:0], 16'h0010, "restart delay");
    // data-ready trigger, retrigger while running is ignored
    config_timing(2'h1, 3'h0, 2'h0);
    @(posedge clk) #1 dataReadyN = 1'b1;
    repeat (4) @(posedge clk);
    #1 dataReadyN = 1'b0;
    wait_for(0, 8);
    chk({15'h0000, seqBusy}, 16'h0001, "pin trigger");
    // two synchroniser flops and the registered seqBusy put three edges before busy
    chk(n[15:0], 16'h0003, "pin latency");
    repeat (3) @(posedge clk);
    #1 dataReadyN = 1'b1;
    repeat (3) @(posedge clk);
    #1 dataReadyN = 1'b0;
    wait_for(1, 5000);
    chk(n[15:0], 16'h000a, "no retrigger");
    wait_for(2, 2000);
    chk(n[15:0], 16'h0180, "no restart");
    pulse_start();
    wait_for(1, 5000);
    chk(n[15:0], 16'h0010, "start in mode 01");
    wait_for(2, 2000);
    // both continuous codes, two steps, repeats with no trigger
    for (int m = 2; m < 4; m++) begin
      config_timing(m[1:0], 3'h1, 2'h1);
      lastStep = 2'h1;
      pulse_start();
      wait_for(1, 5000);
      chk({14'h0000, stepCount}, 16'h0000, "first step");
      for (int s = 1; s < 4; s++) begin
        wait_for(1, 5000);
        chk(n[15:0], 16'h0240, "step pitch");
        chk({14'h0000, stepCount}, {15'h0000, s[0]}, "step index");
      end
      // disabling aborts and clears the counter
      @(posedge clk) #1 enable = 1'b0;
      @(posedge clk) #1 chk({13'h0000, seqBusy, stepCount}, 16'h0000, "disable clears");
      enable = 1'b1;
    end
    complete_run();
  end
endmodule : aux_seq_config_test
